// [design/hpgs_defs.vh]
`ifndef HPGS_DEFS_VH
`define HPGS_DEFS_VH
// Register byte offsets
`define HPGS_OFF_CTRL    4'h0
`define HPGS_OFF_STATUS  4'h4
`define HPGS_OFF_LOAD    4'h8
// Control register field positions
`define HPGS_P7_LSB      6
`define HPGS_P8_LSB      9
`define HPGS_P9_LSB      12
// Reset value and control register field mask
`define HPGS_FUNC_RST    3'h0
`define HPGS_CTRL_MASK   32'h00007FC0
// Function codes
`define HPGS_F_GPI       3'h0
`define HPGS_F_GPO       3'h1
`define HPGS_F_C2        3'h2
`define HPGS_F_C3        3'h3
`define HPGS_F_C4        3'h4
`define HPGS_F_C5        3'h5
`define HPGS_F_C6        3'h6
`define HPGS_F_C7        3'h7
`endif

// [design/hpgs_pin_select.v]
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "hpgs_defs.vh"

// What this block does
// [RL1] Pin nine codes 100/101: attention indicators
// [RL2] Pin nine bits 14:12; 110/111 power indicators
// [RL3] Fields load from memory; reset to default
// [RL4] Strap high: pin nine is port3 power-on
// [RL5] Strap high: pin eight is port3 present
// [RL6] Software leaves strapped fields at default
// [RL7] Code 000 input default, 001 output
// [RL8] Pin eight 010/011: attention buttons
// [RL9] Pin eight 100/101: power-fault inputs
// [RL10] Pin eight 110/111: interlock engage outputs
// [RL11] Pin seven 010: port2 clock request
// [RL12] Pin seven 011: port2 latch sensor
// [RL13] Pin seven 110/111: port1/port3 latch sensors
// [RL14] Pin nine 010/011: interlock control outputs
// [RL15] Pin seven 100/101: port1/port3 power faults
// [RL16] Pin eight field bits 11:9, read/write
// [RL17] Slot inputs routed, slot outputs driven
module hpgs_pin_select (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // Avalon-MM slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Configuration memory load and strap
  input  wire        cfg_mem_load_valid,
  input  wire [8:0]  cfg_mem_load_fields,
  input  wire        port_three_slot_strap,
  // Pins
  input  wire        general_pin_seven_in,
  output reg         general_pin_seven_out,
  output reg         general_pin_seven_oe,
  input  wire        general_pin_eight_in,
  output reg         general_pin_eight_out,
  output reg         general_pin_eight_oe,
  input  wire        general_pin_nine_in,
  output reg         general_pin_nine_out,
  output reg         general_pin_nine_oe,
  // General-purpose data
  input  wire [2:0]  gp_out_data,
  output reg  [2:0]  gp_in_data,
  // Hot-plug logic outputs toward pins
  input  wire        port1_attention_indicator,
  input  wire        port2_attention_indicator,
  input  wire        port1_power_indicator,
  input  wire        port2_power_indicator,
  input  wire        port1_interlock_control,
  input  wire        port2_interlock_control,
  input  wire        port1_interlock_engage,
  input  wire        port2_interlock_engage,
  input  wire        port2_clock_request,
  input  wire        slot_power_on_output,
  // Pin levels toward hot-plug logic
  output reg         port1_attention_button,
  output reg         port2_attention_button,
  output reg         port1_power_fault,
  output reg         port2_power_fault,
  output reg         port3_power_fault,
  output reg         latch_sensor_a,
  output reg         port2_latch_sensor,
  output reg         port3_latch_sensor,
  output reg         port3_card_present,
  output reg         strap_active
);

  reg  [2:0] pin_seven_function_field;
  reg  [2:0] pin_eight_function_field;
  reg  [2:0] pin_nine_function_field;
  reg        strap_taken_reg;
  reg  [2:0] pin_s1_reg;
  reg  [2:0] pin_s2_reg;
  reg        strap_s1_reg;
  reg        strap_s2_reg;
  reg        load_done_reg;
  reg        ack_reg;
  wire       req;
  wire [2:0] pin_in;
  reg  [2:0] p_out;
  reg  [2:0] p_oe;
  reg  [31:0] rd_next;
  wire        pin_eight_free;

  // Input route decode, shared by every routed slot signal except port3_card_present:
  // high only while the field selects the code and the pin is high,
  // so an unselected route never shows a stale pin level
  function route_hit;
    input [2:0] field;
    input [2:0] code;
    input       level;
    begin
      route_hit = (field == code) && level;
    end
  endfunction

  assign pin_in = {general_pin_nine_in, general_pin_eight_in, general_pin_seven_in};
  assign req    = (avs_read | avs_write) & ~ack_reg;

  // Pin eight keeps its field functions only while not strapped
  // [RL5] strap disables pin eight field
  assign pin_eight_free = ~strap_active;

  // Two-flop synchronisers for the pin levels
  // Only the second stage is read; the first may go metastable
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
    end else begin
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // Strap synchroniser, left out of reset on purpose:
  // the strap level held during reset is already settled
  // in the second stage when reset is released
  always @(posedge clk_sys) begin
    strap_s1_reg <= port_three_slot_strap;
    strap_s2_reg <= strap_s1_reg;
  end

  // Strap captured once, first edge after reset release;
  // later strap changes are ignored until the next reset
  // [RL4] strap capture
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      strap_taken_reg <= 1'b0;
      strap_active    <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      strap_active    <= strap_s2_reg;
    end
  end

  // Control fields: reset, memory load, software write
  // [RL3] load and reset
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_seven_function_field <= `HPGS_FUNC_RST;
      pin_eight_function_field <= `HPGS_FUNC_RST;
      pin_nine_function_field  <= `HPGS_FUNC_RST;
      load_done_reg            <= 1'b0;
    end else if (cfg_mem_load_valid) begin
      pin_seven_function_field <= cfg_mem_load_fields[2:0];
      pin_eight_function_field <= cfg_mem_load_fields[5:3];
      pin_nine_function_field  <= cfg_mem_load_fields[8:6];
      load_done_reg            <= 1'b1;
    // Bus write lands at the edge that answers it, while the
    // master still holds address and data; a load in the same
    // cycle wins and the write is lost
    end else if (!avs_waitrequest && avs_write && avs_address == `HPGS_OFF_CTRL) begin
      pin_seven_function_field <= avs_writedata[`HPGS_P7_LSB +: 3];
      // [RL16] pin eight field write
      pin_eight_function_field <= avs_writedata[`HPGS_P8_LSB +: 3];
      // [RL2] pin nine field write
      pin_nine_function_field  <= avs_writedata[`HPGS_P9_LSB +: 3];
    end
  end

  // Read mux
  always @* begin
    rd_next = 32'h00000000;
    case (avs_address)
      `HPGS_OFF_CTRL: begin
        rd_next[`HPGS_P7_LSB +: 3] = pin_seven_function_field;
        rd_next[`HPGS_P8_LSB +: 3] = pin_eight_function_field;
        rd_next[`HPGS_P9_LSB +: 3] = pin_nine_function_field;
      end
      `HPGS_OFF_STATUS: begin
        // Captured strap above the synced pin levels
        rd_next[3]   = strap_active;
        rd_next[2:0] = pin_s2_reg;
      end
      `HPGS_OFF_LOAD: begin
        // Set once a memory load has been seen
        rd_next[0] = load_done_reg;
      end
      default:          rd_next      = 32'h00000000;
    endcase
  end

  // Bus answer one cycle after request
  // The answer cycle blocks a new take, so a held request
  // is never answered twice
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_reg         <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      ack_reg         <= req;
      avs_waitrequest <= ~req;
      if (req && avs_read)
        avs_readdata <= rd_next;
    end
  end

  // Pin drive selection
  always @* begin
    p_out = gp_out_data;
    p_oe  = 3'h0;
    // [RL7] general-purpose modes
    if (pin_seven_function_field == `HPGS_F_GPO) p_oe[0] = 1'b1;
    if (pin_eight_function_field == `HPGS_F_GPO) p_oe[1] = 1'b1;
    if (pin_nine_function_field  == `HPGS_F_GPO) p_oe[2] = 1'b1;
    // [RL11] clock request output
    if (pin_seven_function_field == `HPGS_F_C2) begin
      p_oe[0]  = 1'b1;
      p_out[0] = port2_clock_request;
    end
    // [RL10] interlock engage outputs
    if (pin_eight_function_field == `HPGS_F_C6 || pin_eight_function_field == `HPGS_F_C7) begin
      p_oe[1]  = 1'b1;
      p_out[1] = pin_eight_function_field[0] ? port2_interlock_engage : port1_interlock_engage;
    end
    // [RL1] [RL2] [RL14] pin nine outputs
    case (pin_nine_function_field)
      `HPGS_F_C2: begin
        p_oe[2]  = 1'b1;
        p_out[2] = port1_interlock_control;
      end
      `HPGS_F_C3: begin
        p_oe[2]  = 1'b1;
        p_out[2] = port2_interlock_control;
      end
      `HPGS_F_C4: begin
        p_oe[2]  = 1'b1;
        p_out[2] = port1_attention_indicator;
      end
      `HPGS_F_C5: begin
        p_oe[2]  = 1'b1;
        p_out[2] = port2_attention_indicator;
      end
      `HPGS_F_C6: begin
        p_oe[2]  = 1'b1;
        p_out[2] = port1_power_indicator;
      end
      `HPGS_F_C7: begin
        p_oe[2]  = 1'b1;
        p_out[2] = port2_power_indicator;
      end
      default: begin end
    endcase
    // [RL4] strap overrides pin nine
    if (strap_active) begin
      p_oe[2]  = 1'b1;
      p_out[2] = slot_power_on_output;
      // [RL5] pin eight input only
      p_oe[1]  = 1'b0;
    end
  end

  // Registered pins and routed inputs
  // [RL17] routing of slot signals
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      {general_pin_nine_out, general_pin_eight_out, general_pin_seven_out} <= 3'h0;
      {general_pin_nine_oe, general_pin_eight_oe, general_pin_seven_oe}    <= 3'h0;
      gp_in_data             <= 3'h0;
      port1_attention_button <= 1'b0;
      port2_attention_button <= 1'b0;
      port1_power_fault      <= 1'b0;
      port2_power_fault      <= 1'b0;
      port3_power_fault      <= 1'b0;
      latch_sensor_a         <= 1'b0;
      port2_latch_sensor     <= 1'b0;
      port3_latch_sensor     <= 1'b0;
      port3_card_present     <= 1'b0;
    end else begin
      {general_pin_nine_out, general_pin_eight_out, general_pin_seven_out} <= p_out;
      {general_pin_nine_oe, general_pin_eight_oe, general_pin_seven_oe}    <= p_oe;
      // Synced levels for general-purpose reads, whatever the mode
      gp_in_data <= pin_s2_reg;
      // [RL8] attention buttons
      port1_attention_button <= pin_eight_free && route_hit(pin_eight_function_field, `HPGS_F_C2, pin_s2_reg[1]);
      port2_attention_button <= pin_eight_free && route_hit(pin_eight_function_field, `HPGS_F_C3, pin_s2_reg[1]);
      // [RL9] [RL15] power-fault inputs
      // Port 1 may come from pin eight or from pin seven
      port1_power_fault <= (pin_eight_free && route_hit(pin_eight_function_field, `HPGS_F_C4, pin_s2_reg[1])) ||
                           route_hit(pin_seven_function_field, `HPGS_F_C4, pin_s2_reg[0]);
      port2_power_fault <= pin_eight_free && route_hit(pin_eight_function_field, `HPGS_F_C5, pin_s2_reg[1]);
      port3_power_fault <= route_hit(pin_seven_function_field, `HPGS_F_C5, pin_s2_reg[0]);
      // [RL12] [RL13] latch sensors
      latch_sensor_a     <= route_hit(pin_seven_function_field, `HPGS_F_C6, pin_s2_reg[0]);
      port2_latch_sensor <= route_hit(pin_seven_function_field, `HPGS_F_C3, pin_s2_reg[0]);
      port3_latch_sensor <= route_hit(pin_seven_function_field, `HPGS_F_C7, pin_s2_reg[0]);
      // [RL5] card present from pin eight
      port3_card_present <= strap_active && pin_s2_reg[1];
    end
  end

endmodule // hpgs_pin_select

// [sim/hpgs_slot_model.sv]
`timescale 1ns/1ps
module hpgs_slot_model (
  // Design side of each pin
  input  wire [2:0] pin_oe,
  input  wire [2:0] pin_out,
  // Button, sensor and fault levels
  input  wire [2:0] slot_lvl,
  output wire [2:0] pin_lvl
);
  // Design wins while enabled, else the slot drives
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & slot_lvl);
endmodule // hpgs_slot_model

// [sim/hpgs_pin_select_assertions.sv]
`timescale 1ns/1ps
module hpgs_checker (
  // Clock and bus
  input wire clk_sys,
  input wire rstn,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  // Pins and routes
  input wire strap_active,
  input wire slot_power_on_output,
  input wire general_pin_nine_out,
  input wire general_pin_nine_oe,
  input wire general_pin_eight_oe,
  input wire general_pin_eight_in,
  input wire port3_card_present,
  input wire port1_attention_button,
  input wire port2_attention_button,
  input wire latch_sensor_a,
  input wire port2_latch_sensor,
  input wire port3_latch_sensor
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Bus answer timing, strap takeover, exclusive routes
  ack_next_a: assert property ($rose(avs_read | avs_write) |=> !avs_waitrequest) else $error("no ack");
  ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long ack");
  ack_cause_a: assert property (!avs_waitrequest |-> $past(avs_read | avs_write)) else $error("stray ack");
  strap_power_a:
    assert property (strap_active && $past(strap_active) |-> general_pin_nine_oe &&
      general_pin_nine_out == $past(slot_power_on_output)) else $error("power pin");
  strap_present_a:
    assert property (strap_active && $past(strap_active, 3) |-> !general_pin_eight_oe &&
      port3_card_present == $past(general_pin_eight_in, 3)) else $error("present pin");
  no_present_a: assert property (!strap_active |-> !port3_card_present) else $error("present");
  pin8_route_a:
    assert property ($onehot0({port1_attention_button, port2_attention_button})) else $error("buttons");
  pin7_route_a:
    assert property ($onehot0({latch_sensor_a, port2_latch_sensor, port3_latch_sensor})) else $error("sensors");
endmodule // hpgs_checker

// [sim/hpgs_pin_select_tb.sv]
`timescale 1ns/1ps
module hpgs_pin_select_tb;
  // Drive, observe and score
  reg clk_sys = 1'h0, rstn = 1'h0, avs_read = 1'h0, avs_write = 1'h0, cfg_mem_load_valid = 1'h0;
  reg port_three_slot_strap = 1'h0;
  reg [3:0] avs_address = 4'h0;
  reg [31:0] avs_writedata = 32'h0, rd;
  reg [8:0] cfg_mem_load_fields = 9'h0;
  reg [12:0] stim = 13'h0;
  reg [2:0] slot_lvl = 3'h0;
  wire [31:0] avs_readdata;
  wire [2:0] gp_in_data, pin_oe, pin_out, pin_lvl;
  wire [8:0] routed;
  wire avs_waitrequest, strap_active;
  int o_tab[24] = '{-1,0,11,-1,-1,-1,-1,-1,-1,1,-1,-1,-1,-1,9,10,-1,2,7,8,3,4,5,6};
  int r_tab[24] = '{-1,-1,-1,6,2,4,5,7,-1,-1,0,1,2,3,-1,-1,-1,-1,-1,-1,-1,-1,-1,-1};
  int fail_count = 0, comparisons = 0;
  hpgs_pin_select dut (.*, .general_pin_seven_in(pin_lvl[0]), .general_pin_eight_in(pin_lvl[1]),
    .general_pin_nine_in(pin_lvl[2]), .general_pin_seven_out(pin_out[0]), .general_pin_eight_out(pin_out[1]),
    .general_pin_nine_out(pin_out[2]), .general_pin_seven_oe(pin_oe[0]), .general_pin_eight_oe(pin_oe[1]),
    .general_pin_nine_oe(pin_oe[2]), .gp_out_data(stim[2:0]), .port1_attention_indicator(stim[3]),
    .port2_attention_indicator(stim[4]), .port1_power_indicator(stim[5]), .port2_power_indicator(stim[6]),
    .port1_interlock_control(stim[7]), .port2_interlock_control(stim[8]), .port1_interlock_engage(stim[9]),
    .port2_interlock_engage(stim[10]), .port2_clock_request(stim[11]), .slot_power_on_output(stim[12]),
    .port1_attention_button(routed[0]), .port2_attention_button(routed[1]), .port1_power_fault(routed[2]),
    .port2_power_fault(routed[3]), .port3_power_fault(routed[4]), .latch_sensor_a(routed[5]),
    .port2_latch_sensor(routed[6]), .port3_latch_sensor(routed[7]), .port3_card_present(routed[8]));
  hpgs_slot_model slot (.pin_oe(pin_oe), .pin_out(pin_out), .slot_lvl(slot_lvl), .pin_lvl(pin_lvl));
  always #2.5 clk_sys = ~clk_sys;
  task check(input string n, input [31:0] seen, input [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // One bus cycle, held until waitrequest is seen low
  task bus(input w, input [3:0] a, input [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  task do_reset(input s);
    port_three_slot_strap <= s;
    rstn <= 1'h0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'h1;
    repeat (2) @(posedge clk_sys);
  endtask
  // One field code, both levels, pin and routes judged
  task run_code(input int p, input int c);
    int o, r;
    o = o_tab[p * 8 + c];
    r = r_tab[p * 8 + c];
    bus(1'h1, 4'h0, c << (6 + 3 * p));
    for (int lv = 0; lv < 2; lv++) begin
      stim <= lv ? 13'h1 << o : ~(13'h1 << o);
      slot_lvl <= lv ? 3'h1 << p : ~(3'h1 << p);
      repeat (5) @(posedge clk_sys);
      check("pin oe", pin_oe[p], o >= 0);
      if (o >= 0) check("pin out", pin_out[p], lv);
      check("routes", routed, (r >= 0 && lv) ? 9'h1 << r : 9'h0);
      if (c == 0) check("gp in", gp_in_data[p], lv);
    end
  endtask
  task tally_and_finish;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    do_reset(1'h0);
    bus(1'h0, 4'h0, 32'h0);
    check("ctrl reset", rd, 32'h0);
    bus(1'h0, 4'hC, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'h1, 4'h0, 32'hFFFFFFFF);
    bus(1'h0, 4'h0, 32'h0);
    check("ctrl rw", rd, 32'h00007FC0);
    for (int i = 0; i < 24; i++) run_code(i / 8, i % 8);
    @(posedge clk_sys);
    cfg_mem_load_fields <= 9'h1A5;
    cfg_mem_load_valid <= 1'h1;
    @(posedge clk_sys);
    cfg_mem_load_valid <= 1'h0;
    bus(1'h0, 4'h0, 32'h0);
    check("ctrl load", rd, 32'h00006940);
    bus(1'h0, 4'h8, 32'h0);
    check("load seen", rd, 32'h1);
    do_reset(1'h1);
    bus(1'h0, 4'h0, 32'h0);
    check("ctrl cleared", rd, 32'h0);
    bus(1'h0, 4'h8, 32'h0);
    check("load cleared", rd, 32'h0);
    bus(1'h0, 4'h4, 32'h0);
    check("strap", rd[3], 1'h1);
    for (int lv = 0; lv < 2; lv++) begin
      stim <= {lv[0], 12'h0};
      slot_lvl <= {1'h0, lv[0], 1'h0};
      repeat (5) @(posedge clk_sys);
      check("power on", {pin_oe[2], pin_out[2]}, {1'h1, lv[0]});
      check("present", {pin_oe[1], routed}, {1'h0, lv[0], 8'h0});
    end
    tally_and_finish;
  end
endmodule // hpgs_pin_select_tb
bind hpgs_pin_select hpgs_checker u_chk (.*);
